// >>> shared/flash_rd_pkg.sv
// Shared constants and types for the serial flash read sequencer
package flash_rd_pkg;
	localparam logic [7:0] OPC_BASIC = 8'h03;
	localparam logic [7:0] OPC_BASIC_W = 8'h13;
	localparam logic [7:0] OPC_FAST = 8'h0B;
	localparam logic [7:0] OPC_FAST_W = 8'h0C;
	localparam logic [7:0] OPC_QUAD = 8'hEB;
	localparam logic [7:0] OPC_QUAD_W = 8'hEC;
	localparam logic [7:0] OPC_MODE_RESET = 8'hFF;
	localparam logic [3:0] MODE_CONT_NIB = 4'hA;
	localparam logic [3:0] ALL_ONES_NIB = 4'hF;
	localparam logic [5:0] NARROW_BITS = 6'h18;
	localparam logic [5:0] WIDE_BITS = 6'h20;
	localparam logic [5:0] OPC_LAST_SERIAL = 6'h07;
	localparam logic [5:0] OPC_LAST_NIBBLE = 6'h01;
	localparam logic [5:0] MODE_LAST = 6'h01;
	localparam logic [7:0] OE_SINGLE = 8'h22;
	localparam logic [7:0] OE_QUAD = 8'hFF;
	localparam int BASIC_MAX_MHZ = 50;
	localparam int FAST_MAX_MHZ = 133;
	localparam int QUAD_MAX_MHZ = 133;
	localparam int ARRAY_AW = 24;
	localparam int FIFO_DEPTH = 4;

	typedef struct packed {
		logic wide_addr;
		logic quad_enable;
		logic four_bit_instruction_mode;
		logic [3:0] latency_code;
	} cfg_t;

	typedef enum logic [1:0] {rk_basic, rk_fast, rk_quad} read_kind_t;

	typedef enum logic [2:0] {st_idle, st_opc, st_addr, st_mode, st_dummy, st_data, st_ignore} seq_state_t;
endpackage

// >>> hw/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [PW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || flush) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= bump(wr_r);
			end
			if (pop) begin
				rd_r <= bump(rd_r);
			end
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// >>> hw/flash_read_seq.sv
// Device-side read command sequencer: opcode, address, mode, latency and data phases
//
// Behaviour
// - 03h takes 3 or 4 address bytes per config
// - 13h always takes a 32-bit address
// - Basic read data on lines 1 and 5
// - Any start byte; address advances per byte
// - Address counter wraps to zero past top
// - 0Bh per config width, 0Ch always wide
// - Fast read waits latency code dummy cycles
// - Fast read dummy cycle inputs are ignored
// - EBh per config width, ECh always wide
// - Quad read only when quad enable set
// - Quad read dummies after mode, inputs ignored
// - Quad data one byte per falling edge
// - Mode nibble A keeps instruction-less repeat access
// - Other mode bits leave repeat mode on deselect
// - Mode reset command leaves repeat mode
// - Mode byte over two clocks after address
// - Four-bit instruction mode takes nibble opcodes
// - Otherwise opcode arrives one bit per edge
// - Select rising ends the read at once
// - Dummies counted fall to fall; zero allowed
`timescale 1ns/1ns
module flash_read_seq #(
	parameter int AW = flash_rd_pkg::ARRAY_AW,
	parameter int DEPTH = flash_rd_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic [7:0] io_oe,
	input wire flash_rd_pkg::cfg_t cfg,
	output logic execute_in_place,
	output logic mem_rd,
	output logic [AW-1:0] mem_addr,
	input wire logic [7:0] mem_rdata
);
	import flash_rd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; link clock is sampled, not used as a clock

	logic sck_s1, sck_s2, sck_s3;
	logic cs_s1, cs_s2, cs_s3;
	logic [7:0] io_s1, io_s2;
	logic rise, fall, cs_rise, cs_fall;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
		end else begin
			sck_s1 <= sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			io_s1 <= io_in;
			io_s2 <= io_s1;
		end
	end

	// Inputs share the clock's sync delay, so sampling at the detected edge stays aligned
	assign rise = sck_s2 && !sck_s3 && !cs_s2;
	assign fall = !sck_s2 && sck_s3 && !cs_s2;
	assign cs_rise = cs_s2 && !cs_s3;
	assign cs_fall = !cs_s2 && cs_s3;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [5:0] addr_last(input logic wide, input logic quad);
		logic [5:0] bits;
		bits = wide ? WIDE_BITS : NARROW_BITS;
		addr_last = quad ? (bits >> 2) - 6'h01 : bits - 6'h01;
	endfunction

	function automatic logic [7:0] single_lanes(input logic hi, input logic lo);
		single_lanes = {2'b00, hi, 3'b000, lo, 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Phase sequencing

	seq_state_t state_r;
	read_kind_t kind_r;
	logic [5:0] cnt_r;
	logic [5:0] addr_last_r;
	logic [3:0] lat_r;
	logic wide_r;
	logic [7:0] opc_r;
	logic [31:0] addr_r;
	logic [7:0] opc_nxt;
	logic [31:0] addr_nxt;
	logic [5:0] opc_last;
	logic opc_done, addr_done, data_go;
	read_kind_t dec_kind;
	logic dec_ok;
	logic dec_wide;

	assign opc_last = cfg.four_bit_instruction_mode ? OPC_LAST_NIBBLE : OPC_LAST_SERIAL;
	assign opc_nxt = cfg.four_bit_instruction_mode ? {opc_r[3:0], io_s2[3:0]} : {opc_r[6:0], io_s2[0]};
	assign addr_nxt = (kind_r == rk_quad) ? {addr_r[27:0], io_s2[3:0]} : {addr_r[30:0], io_s2[0]};
	assign opc_done = (state_r == st_opc) && rise && (cnt_r == opc_last);
	assign addr_done = (state_r == st_addr) && rise && (cnt_r == addr_last_r);
	// Zero latency drives data on the first fall after the last input edge
	assign data_go = fall && (((state_r == st_dummy) && (cnt_r[3:0] == lat_r)) || (state_r == st_data));

	always_comb begin
		dec_kind = rk_basic;
		dec_ok = 1'b1;
		dec_wide = cfg.wide_addr;
		unique case (opc_nxt)
			OPC_BASIC: dec_kind = rk_basic;
			OPC_BASIC_W: dec_wide = 1'b1;
			OPC_FAST: dec_kind = rk_fast;
			OPC_FAST_W: begin
				dec_kind = rk_fast;
				dec_wide = 1'b1;
			end
			OPC_QUAD: begin
				dec_kind = rk_quad;
				dec_ok = cfg.quad_enable;
			end
			OPC_QUAD_W: begin
				dec_kind = rk_quad;
				dec_wide = 1'b1;
				dec_ok = cfg.quad_enable;
			end
			default: dec_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= st_idle;
			kind_r <= rk_basic;
			cnt_r <= 6'h00;
			addr_last_r <= 6'h00;
			lat_r <= 4'h0;
			wide_r <= 1'b0;
			opc_r <= 8'h00;
			addr_r <= 32'h0000_0000;
		end else if (cs_rise) begin
			state_r <= st_idle;
		end else if (cs_fall) begin
			cnt_r <= 6'h00;
			opc_r <= 8'h00;
			addr_r <= 32'h0000_0000;
			if (execute_in_place) begin
				state_r <= st_addr;
				kind_r <= rk_quad;
				addr_last_r <= addr_last(wide_r, 1'b1);
			end else begin
				state_r <= st_opc;
			end
		end else begin
			unique case (state_r)
				st_opc: if (rise) begin
					opc_r <= opc_nxt;
					cnt_r <= cnt_r + 6'h01;
					if (opc_done) begin
						cnt_r <= 6'h00;
						kind_r <= dec_kind;
						wide_r <= dec_wide;
						addr_last_r <= addr_last(dec_wide, dec_kind == rk_quad);
						// Basic read has no latency regardless of the code
						lat_r <= (dec_kind == rk_basic) ? 4'h0 : cfg.latency_code;
						state_r <= dec_ok ? st_addr : st_ignore;
					end
				end
				st_addr: if (rise) begin
					addr_r <= addr_nxt;
					cnt_r <= cnt_r + 6'h01;
					if (addr_done) begin
						cnt_r <= 6'h00;
						state_r <= (kind_r == rk_quad) ? st_mode : st_dummy;
					end
				end
				st_mode: if (rise) begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == MODE_LAST) begin
						cnt_r <= 6'h00;
						state_r <= st_dummy;
					end
				end
				// Line values are not looked at here at all
				st_dummy: if (fall) begin
					if (cnt_r[3:0] == lat_r) begin
						state_r <= st_data;
					end else begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				st_idle, st_data, st_ignore: state_r <= state_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Repeat-access (instruction-less) mode tracking

	logic repeat_r;
	logic mode_cont_r;
	logic mode_seen_r;
	logic ff_ok_r;

	assign execute_in_place = repeat_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			repeat_r <= 1'b0;
			mode_cont_r <= 1'b0;
			mode_seen_r <= 1'b0;
			ff_ok_r <= 1'b0;
		end else if (cs_rise) begin
			// Deselect inside mode leaves the old mode (indeterminate by protocol); deselect in dummy applies the new mode bits
			if (mode_seen_r) begin
				repeat_r <= mode_cont_r;
			end else if (repeat_r && (state_r == st_addr) && ff_ok_r && (cnt_r != 6'h00)) begin
				repeat_r <= 1'b0;
			end
		end else if (cs_fall) begin
			mode_seen_r <= 1'b0;
			ff_ok_r <= 1'b1;
		end else begin
			if (opc_done && (opc_nxt == OPC_MODE_RESET)) begin
				repeat_r <= 1'b0;
			end
			if ((state_r == st_addr) && rise) begin
				ff_ok_r <= ff_ok_r && (io_s2[3:0] == ALL_ONES_NIB);
			end
			if ((state_r == st_mode) && rise) begin
				if (cnt_r == 6'h00) begin
					mode_cont_r <= (io_s2[3:0] == MODE_CONT_NIB);
				end else begin
					mode_seen_r <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Array fetch into the byte FIFO

	logic fetch_on_r;
	logic in_flight_r;
	logic rd_d_r;
	logic mem_rd_r;
	logic [AW-1:0] mem_addr_r;
	logic [AW-1:0] fetch_addr_r;
	logic issue;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic pop;

	assign mem_rd = mem_rd_r;
	assign mem_addr = mem_addr_r;
	// One request in flight keeps a free slot guaranteed when the data returns
	assign issue = fetch_on_r && !in_flight_r && fifo_in_ready && !cs_rise && !cs_fall;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fetch_on_r <= 1'b0;
			in_flight_r <= 1'b0;
			rd_d_r <= 1'b0;
			mem_rd_r <= 1'b0;
			mem_addr_r <= '0;
			fetch_addr_r <= '0;
		end else begin
			mem_rd_r <= issue;
			rd_d_r <= mem_rd_r;
			if (issue) begin
				mem_addr_r <= fetch_addr_r;
				fetch_addr_r <= fetch_addr_r + 1'b1;
				in_flight_r <= 1'b1;
			end else if (rd_d_r) begin
				in_flight_r <= 1'b0;
			end
			if (cs_rise || cs_fall) begin
				fetch_on_r <= 1'b0;
				in_flight_r <= 1'b0;
			end else if (addr_done) begin
				fetch_on_r <= 1'b1;
				fetch_addr_r <= addr_nxt[AW-1:0];
			end
		end
	end

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.flush(cs_rise || cs_fall),
		.in_valid(rd_d_r && fetch_on_r),
		.in_ready(fifo_in_ready),
		.in_data(mem_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Data output, launched on falling clock edges

	logic [7:0] dout_r;
	logic [1:0] chunk_r;
	logic [7:0] io_out_r;
	logic [7:0] io_oe_r;
	logic [7:0] byte_now;

	assign pop = data_go && (chunk_r == 2'b00);
	// An underrun sends zeros rather than stalling the host's clock
	assign byte_now = fifo_out_valid ? fifo_out_data : 8'h00;
	assign io_out = io_out_r;
	assign io_oe = io_oe_r;

	always_ff @(posedge sys_clk) begin
		if (rst || cs_rise) begin
			dout_r <= 8'h00;
			chunk_r <= 2'b00;
			io_out_r <= 8'h00;
			io_oe_r <= 8'h00;
		end else if (data_go) begin
			if (kind_r == rk_quad) begin
				io_out_r <= byte_now;
				io_oe_r <= OE_QUAD;
			end else if (chunk_r == 2'b00) begin
				io_out_r <= single_lanes(byte_now[7], byte_now[6]);
				io_oe_r <= OE_SINGLE;
				dout_r <= {byte_now[5:0], 2'b00};
				chunk_r <= 2'b01;
			end else begin
				io_out_r <= single_lanes(dout_r[7], dout_r[6]);
				dout_r <= {dout_r[5:0], 2'b00};
				chunk_r <= chunk_r + 2'b01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_cs_rise_quiet;
		cs_rise |=> (io_oe_r == 8'h00) && (state_r == st_idle);
	endproperty
	a_cs_rise_quiet: assert property (p_cs_rise_quiet) else $error("select rise did not end the read");

	property p_quad_gate;
		opc_done && (dec_kind == rk_quad) && !cfg.quad_enable |=> state_r == st_ignore;
	endproperty
	a_quad_gate: assert property (p_quad_gate) else $error("quad read ran without quad enable");

	property p_repeat_entry;
		cs_fall && repeat_r |=> (state_r == st_addr) && (kind_r == rk_quad);
	endproperty
	a_repeat_entry: assert property (p_repeat_entry) else $error("repeat access did not skip the opcode");

	property p_mode_len;
		(state_r == st_mode) && rise && (cnt_r == MODE_LAST) && !cs_fall |=> state_r == st_dummy;
	endproperty
	a_mode_len: assert property (p_mode_len) else $error("mode phase not two clocks");

	property p_dummy_end;
		(state_r == st_dummy) && fall && (cnt_r[3:0] == lat_r) |=> (state_r == st_data) && (io_oe_r != 8'h00);
	endproperty
	a_dummy_end: assert property (p_dummy_end) else $error("data not driven at end of latency");

	property p_dummy_quiet;
		(state_r == st_dummy) |-> io_oe_r == 8'h00;
	endproperty
	a_dummy_quiet: assert property (p_dummy_quiet) else $error("lines driven during dummy cycles");

	property p_wrap;
		issue && (fetch_addr_r == {AW{1'b1}}) |=> fetch_addr_r == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("address counter did not wrap");

	property p_incr;
		issue && (fetch_addr_r != {AW{1'b1}}) |=> fetch_addr_r == $past(fetch_addr_r) + 1'b1;
	endproperty
	a_incr: assert property (p_incr) else $error("address did not advance by one");

	property p_quad_lanes;
		(state_r == st_data) && (kind_r == rk_quad) && fall |=> io_oe_r == OE_QUAD;
	endproperty
	a_quad_lanes: assert property (p_quad_lanes) else $error("quad data not on eight lines");

	property p_single_lanes;
		(state_r == st_data) && (kind_r != rk_quad) && fall |=> io_oe_r == OE_SINGLE;
	endproperty
	a_single_lanes: assert property (p_single_lanes) else $error("single data not on lines 1 and 5");

	property p_basic_len;
		opc_done && (opc_nxt == OPC_BASIC) && !cfg.wide_addr |=> addr_last_r == NARROW_BITS - 6'h01;
	endproperty
	a_basic_len: assert property (p_basic_len) else $error("basic read address length wrong");

	property p_wide_len;
		opc_done && (opc_nxt == OPC_BASIC_W) |=> addr_last_r == WIDE_BITS - 6'h01;
	endproperty
	a_wide_len: assert property (p_wide_len) else $error("wide basic read not 32-bit address");

	c_quad_data: cover property ((state_r == st_data) && (kind_r == rk_quad) && fall);
	c_repeat_reentry: cover property (cs_fall && repeat_r);
	c_wrap: cover property (issue && (fetch_addr_r == {AW{1'b1}}));
	c_single_data: cover property ((state_r == st_data) && (kind_r == rk_fast) && fall);
endmodule

// >>> test/flash_host_model.sv
// Host controller model: serial clock, select and line drive for read frames
`timescale 1ns/1ns
module flash_host_model (
	input wire logic sys_clk,
	output logic sck,
	output logic cs_n,
	output logic [7:0] io_in,
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe
);
	logic [7:0] drv_r;
	logic drv_en_r;
	logic [7:0] oe_seen;
	logic [7:0] q[$];

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		drv_r = 8'h00;
		drv_en_r = 1'b0;
		oe_seen = 8'h00;
	end

	// Released lines show the inverse of the last value so a stale level never passes
	assign io_in = (io_oe & io_out) | (~io_oe & (drv_en_r ? drv_r : ~drv_r));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Launch on the fall, sample device lines just before the rise; 80 ns period
	task automatic cycle(input logic [7:0] v, input logic en, output logic [7:0] smp);
		@(posedge sys_clk);
		sck <= 1'b0;
		drv_r <= v;
		drv_en_r <= en;
		wait_clk(10);
		smp = io_in;
		oe_seen = io_oe;
		sck <= 1'b1;
		wait_clk(9);
	endtask

	task automatic send(input logic [31:0] v, input int n, input logic quad);
		logic [7:0] s;
		for (int i = n - 1; i >= 0; i--) begin
			cycle(quad ? {4'h0, v[4*i+:4]} : {7'h00, v[i]}, 1'b1, s);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// om: 0 no opcode, 1 serial opcode, 2 nibble opcode; nb < 0 skips the mode byte and the data
	task automatic rd(input logic [7:0] opc, input int om, input logic [31:0] adr, input int au,
			input logic quad, input logic [7:0] mode, input int dum, input int nb);
		logic [7:0] s;
		logic [7:0] b;
		q.delete();
		b = 8'h00;
		@(posedge sys_clk);
		cs_n <= 1'b0;
		wait_clk(9);
		if (om == 1) send({24'h0, opc}, 8, 1'b0);
		if (om == 2) send({24'h0, opc}, 2, 1'b1);
		send(adr, au, quad);
		if (quad && nb >= 0) send({24'h0, mode}, 2, 1'b1);
		// Lines are let go for the latency so the device can turn the bus round
		repeat (dum) cycle(8'h00, 1'b0, s);
		for (int i = 0; i < nb; i++) begin
			if (quad) begin
				cycle(8'h00, 1'b0, s);
				b = s;
			end else begin
				repeat (4) begin
					cycle(8'h00, 1'b0, s);
					b = {b[5:0], s[5], s[1]};
				end
			end
			q.push_back(b);
		end
		@(posedge sys_clk);
		cs_n <= 1'b1;
		drv_en_r <= 1'b0;
		wait_clk(10);
		sck <= 1'b0;
		wait_clk(30);
	endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the read sequencer with a host model and array model
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
	import flash_rd_pkg::*;
	logic sys_clk;
	logic rst;
	cfg_t cfg;
	logic sck;
	logic cs_n;
	logic [7:0] io_in;
	logic [7:0] io_out;
	logic [7:0] io_oe;
	logic execute_in_place;
	logic mem_rd;
	logic [7:0] mem_addr;
	logic [7:0] mem_rdata;
	int err_total;
	int checked;
	int cyc;

	// Small array so the counter wrap is reached in a few bytes
	flash_read_seq #(.AW(8), .DEPTH(4)) dut (.sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .execute_in_place(execute_in_place),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
	flash_host_model host (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe));

	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	// Array answers one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (mem_rd) mem_rdata <= mem_addr ^ 8'h5A;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic run(input string nm, input cfg_t c, input logic [7:0] opc, input int om,
			input logic [31:0] adr, input int au, input logic quad, input logic [7:0] mode,
			input int dum, input int nb, input logic [7:0] oe_exp);
		@(posedge sys_clk);
		cfg <= c;
		host.rd(opc, om, adr, au, quad, mode, dum, nb);
		`CHK(host.oe_seen, oe_exp)
		if (oe_exp !== 8'h00) begin
			for (int i = 0; i < nb; i++) begin
				`CHK(host.q[i], 8'(adr[7:0] + i) ^ 8'h5A)
			end
		end
		`CHK(io_oe, 8'h00)
		$display("test %s done", nm);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		cfg = '0;
		err_total = 0;
		checked = 0;
		cyc = 0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		run("basic_narrow", '{1'b0, 1'b1, 1'b0, 4'h3}, OPC_BASIC, 1, 32'h0000FE, 24, 1'b0, 8'h00, 0, 4, OE_SINGLE);
		run("basic_wide", '{1'b1, 1'b0, 1'b0, 4'h0}, OPC_BASIC, 1, 32'h000000FD, 32, 1'b0, 8'h00, 0, 3, OE_SINGLE);
		run("basic_w_op", '{1'b0, 1'b0, 1'b0, 4'h0}, OPC_BASIC_W, 1, 32'h00000041, 32, 1'b0, 8'h00, 0, 2, OE_SINGLE);
		run("fast_lat3", '{1'b0, 1'b0, 1'b0, 4'h3}, OPC_FAST, 1, 32'h0000FF, 24, 1'b0, 8'h00, 3, 2, OE_SINGLE);
		run("fast_w_lat0", '{1'b0, 1'b0, 1'b0, 4'h0}, OPC_FAST_W, 1, 32'h00000010, 32, 1'b0, 8'h00, 0, 2, OE_SINGLE);
		run("quad_enter", '{1'b0, 1'b1, 1'b0, 4'h2}, OPC_QUAD, 1, 32'h0000FD, 6, 1'b1, 8'hA5, 2, 4, OE_QUAD);
		`CHK(execute_in_place, 1'b1)
		run("quad_repeat", '{1'b0, 1'b1, 1'b0, 4'h2}, 8'h00, 0, 32'h000022, 6, 1'b1, 8'h50, 2, 2, OE_QUAD);
		`CHK(execute_in_place, 1'b0)
		run("quad_off", '{1'b0, 1'b0, 1'b0, 4'h1}, OPC_QUAD, 1, 32'h000030, 6, 1'b1, 8'h00, 1, 2, 8'h00);
		run("nibble_opc", '{1'b0, 1'b1, 1'b1, 4'h1}, OPC_QUAD_W, 2, 32'h0000007E, 8, 1'b1, 8'hA0, 1, 3, OE_QUAD);
		`CHK(execute_in_place, 1'b1)
		run("mode_reset", '{1'b0, 1'b1, 1'b0, 4'h1}, 8'h00, 0, 32'h0000FF, 2, 1'b1, 8'h00, 0, -1, 8'h00);
		`CHK(execute_in_place, 1'b0)
		run("after_reset", '{1'b0, 1'b1, 1'b0, 4'h0}, OPC_BASIC, 1, 32'h000080, 24, 1'b0, 8'h00, 0, 1, OE_SINGLE);
		run("reset_opc", '{1'b0, 1'b1, 1'b0, 4'h0}, OPC_MODE_RESET, 1, 32'h000040, 24, 1'b0, 8'h00, 0, 2, 8'h00);
		`CHK(execute_in_place, 1'b0)
		complete_run();
	end
endmodule
